// ### rtl/ank_abort_nack.sv
// Acknowledge-failure abort flags and forced slave data NACK, with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "ank_defs.svh"

module ank_abort_nack #(
   parameter bit SLV_NACK_EN = 1'b1
) (
   input  wire logic                 pclk,           // System clock
   input  wire logic                 presetn,        // Async reset
   input  wire logic                 ce,             // Clock enable
   input  wire logic [11:0]          paddr,          // APB address
   input  wire logic                 psel,           // APB select
   input  wire logic                 penable,        // APB enable
   input  wire logic                 pwrite,         // APB direction
   input  wire logic [31:0]          pwdata,         // APB write data
   output logic      [31:0]          prdata,         // APB read data
   output logic                      pready,         // APB ready
   output logic                      pslverr,        // APB error
   input  wire logic                 scl_in,         // Serial clock pin
   input  wire logic                 sda_in,         // Serial data pin
   input  wire logic                 master_mode,    // Controller is master
   input  wire logic                 addr_10bit,     // 10-bit addressing
   input  wire logic                 slave_activity, // Slave part busy
   input  wire ank_pkg::ank_slv_rx_t slave_rx,       // Received slave byte
   output logic                      rx_push,        // Push to rx buffer
   output logic      [7:0]           rx_push_data,   // Byte pushed
   output logic                      slave_nack,     // NACK last byte
   output logic                      slave_abort,    // Slave rx aborted
   output logic                      master_stop_req,// End master transfer
   output logic                      tx_abort,       // Transmit-abort event
   output logic                      controller_en,  // Enable bit
   output logic                      irq             // Interrupt
);

   // ==========================================================
   // Pin synchronisers and bus condition detection
   logic       scl_s1;
   logic       scl_s2;
   logic       scl_d;
   logic       sda_s1;
   logic       sda_s2;
   logic       sda_d;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d  <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d  <= 1'b1;
      end else if (ce) begin
         scl_s1 <= scl_in;
         scl_s2 <= scl_s1;
         scl_d  <= scl_s2;
         sda_s1 <= sda_in;
         sda_s2 <= sda_s1;
         sda_d  <= sda_s2;
      end
   end

   logic scl_rise;
   logic bus_start;
   logic bus_stop;

   assign scl_rise  = scl_s2 & ~scl_d;
   assign bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
   assign bus_stop  = scl_s2 & scl_d & ~sda_d & sda_s2;

   // ==========================================================
   // Transfer phase tracking
   ank_pkg::ank_phase_t phase;
   logic [3:0]          bit_cnt;
   logic                rd_dir;
   logic                aborted;
   logic                ack_slot;

   assign ack_slot = scl_rise && (bit_cnt == `ANK_ACK_SLOT);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase <= ank_pkg::PH_IDLE;
      end else if (ce) begin
         if (bus_stop) begin
            phase <= ank_pkg::PH_IDLE;
         end else if (bus_start) begin
            phase <= ank_pkg::PH_ADDR1;
         end else if (ack_slot) begin
            case (phase)
               ank_pkg::PH_ADDR1: begin
                  phase <= addr_10bit ? ank_pkg::PH_ADDR2 : ank_pkg::PH_DATA;
               end
               ank_pkg::PH_ADDR2: begin
                  phase <= ank_pkg::PH_DATA;
               end
               default: begin
                  phase <= phase;
               end
            endcase
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_cnt <= 4'h0;
         rd_dir  <= 1'b0;
      end else if (ce) begin
         if (bus_start || bus_stop) begin
            bit_cnt <= 4'h0;
         end else if (scl_rise) begin
            bit_cnt <= ack_slot ? 4'h0 : bit_cnt + 4'h1;
            // Direction bit ends the first address byte
            if (phase == ank_pkg::PH_ADDR1 && bit_cnt == `ANK_DIR_SLOT) begin
               rd_dir <= sda_s2;
            end
         end
      end
   end

   // ==========================================================
   // Acknowledge-failure detection
   logic                nack_seen;
   ank_pkg::ank_abort_t abort_set;

   assign nack_seen = ack_slot && sda_s2 && master_mode && controller_en && !aborted;

   always_comb begin
      abort_set = '0;
      if (nack_seen) begin
         case (phase)
            ank_pkg::PH_ADDR1: begin
               abort_set.long_addr_byte1_not_acked = addr_10bit;
               abort_set.short_addr_not_acked      = !addr_10bit;
            end
            ank_pkg::PH_ADDR2: begin
               abort_set.long_addr_byte2_not_acked = 1'b1;
            end
            ank_pkg::PH_DATA: begin
               abort_set.data_not_acked = !rd_dir;
            end
            default: begin
               abort_set = '0;
            end
         endcase
      end
   end

   // One abort per transfer, until the bus is released or restarted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aborted <= 1'b0;
      end else if (ce) begin
         if (bus_start || bus_stop) begin
            aborted <= 1'b0;
         end else if (|abort_set) begin
            aborted <= 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         master_stop_req <= 1'b0;
         tx_abort        <= 1'b0;
      end else if (ce) begin
         master_stop_req <= |abort_set;
         tx_abort        <= |abort_set;
      end
   end

   // ==========================================================
   // APB slave
   logic        apb_done;
   logic        wr_done;
   logic        rd_done;
   logic        nack_ctrl;
   logic        force_nack;
   logic [1:0]  intr_stat;
   logic [1:0]  intr_mask;
   logic [31:0] rd_mux;
   logic        rd_hit;
   ank_pkg::ank_abort_t abort_src;

   assign apb_done   = psel & penable & pready;
   assign wr_done    = apb_done & pwrite;
   assign rd_done    = apb_done & ~pwrite;
   assign force_nack = SLV_NACK_EN & nack_ctrl;

   always_comb begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      if (paddr == `ANK_OFF_INTR_STAT) begin
         rd_mux[1:0] = intr_stat;
      end else if (paddr == `ANK_OFF_INTR_MASK) begin
         rd_mux[1:0] = intr_mask;
      end else if (paddr == `ANK_OFF_CLR_ABORT || paddr == `ANK_OFF_ABORT_SRC) begin
         rd_mux[3:0] = abort_src;
      end else if (paddr == `ANK_OFF_ENABLE) begin
         rd_mux[`ANK_BIT_ENABLE] = controller_en;
      end else if (paddr == `ANK_OFF_STATUS) begin
         rd_mux[`ANK_BIT_SLV_ACT] = slave_activity;
      end else if (paddr == `ANK_OFF_NACK_CTRL) begin
         rd_mux[0] = force_nack;
      end else begin
         rd_hit = 1'b0;
      end
   end

   // Ready one cycle into the access phase; read data snapshot taken then
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready <= psel & penable & ~pready;
         if (psel & penable & ~pready) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= ~rd_hit;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         controller_en <= `ANK_RST_ENABLE;
         intr_mask     <= `ANK_RST_MASK;
      end else if (ce && wr_done) begin
         if (paddr == `ANK_OFF_ENABLE) begin
            controller_en <= pwdata[`ANK_BIT_ENABLE];
         end else if (paddr == `ANK_OFF_INTR_MASK) begin
            intr_mask <= pwdata[1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nack_ctrl <= `ANK_RST_NACK;
      end else if (ce && wr_done && paddr == `ANK_OFF_NACK_CTRL) begin
         if (SLV_NACK_EN && !controller_en && !slave_activity) begin
            nack_ctrl <= pwdata[0];
         end
      end
   end

   // Only bits returned to software are cleared, so a new set is never lost
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         abort_src <= '0;
      end else if (ce) begin
         if (rd_done && paddr == `ANK_OFF_CLR_ABORT) begin
            abort_src <= abort_set | (abort_src & ~prdata[3:0]);
         end else begin
            abort_src <= abort_set | abort_src;
         end
      end
   end

   // ==========================================================
   // Slave receiver data acknowledge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_push      <= 1'b0;
         rx_push_data <= 8'h00;
         slave_nack   <= 1'b0;
         slave_abort  <= 1'b0;
      end else if (ce) begin
         rx_push     <= slave_rx.valid & ~force_nack & slave_rx.normal_ack;
         slave_abort <= slave_rx.valid & force_nack;
         if (slave_rx.valid) begin
            rx_push_data <= slave_rx.data;
            slave_nack   <= force_nack | ~slave_rx.normal_ack;
         end
      end
   end

   // ==========================================================
   // Interrupts
   logic [1:0] next_intr;

   always_comb begin
      next_intr = intr_stat;
      if (rd_done && paddr == `ANK_OFF_INTR_STAT) begin
         next_intr = intr_stat & ~prdata[1:0];
      end
      next_intr[`ANK_INT_TX_ABORT] = next_intr[`ANK_INT_TX_ABORT] | (|abort_set);
      next_intr[`ANK_INT_SLV_NACK] = next_intr[`ANK_INT_SLV_NACK] | (slave_rx.valid & force_nack);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         intr_stat <= 2'h0;
         irq       <= 1'b0;
      end else if (ce) begin
         intr_stat <= next_intr;
         irq       <= |(next_intr & intr_mask);
      end
   end

   // ==========================================================
   // Assertions
   a_data_nack_flag: assert property (@(posedge pclk) disable iff (!presetn)
      ce && nack_seen && phase == ank_pkg::PH_DATA && !rd_dir |=> abort_src.data_not_acked)
      else $error("data nack did not set abort bit 3");

   a_long2_nack_flag: assert property (@(posedge pclk) disable iff (!presetn)
      ce && nack_seen && phase == ank_pkg::PH_ADDR2 |=> abort_src.long_addr_byte2_not_acked)
      else $error("second address byte nack did not set abort bit 2");

   a_long1_nack_flag: assert property (@(posedge pclk) disable iff (!presetn)
      ce && nack_seen && phase == ank_pkg::PH_ADDR1 && addr_10bit
      |=> abort_src.long_addr_byte1_not_acked && !abort_src.short_addr_not_acked)
      else $error("first address byte nack did not set abort bit 1 alone");

   a_short_nack_flag: assert property (@(posedge pclk) disable iff (!presetn)
      ce && nack_seen && phase == ank_pkg::PH_ADDR1 && !addr_10bit |=> abort_src.short_addr_not_acked)
      else $error("7-bit address nack did not set abort bit 0");

   a_nack_write_gate: assert property (@(posedge pclk) disable iff (!presetn)
      ce && wr_done && paddr == `ANK_OFF_NACK_CTRL && (controller_en || slave_activity)
      |=> $stable(nack_ctrl))
      else $error("nack control written while enabled or slave busy");

   a_nack_absent: assert property (@(posedge pclk) disable iff (!presetn)
      !SLV_NACK_EN |-> !force_nack && prdata[0] == 1'b0 || paddr != `ANK_OFF_NACK_CTRL)
      else $error("absent nack control register has effect");

   a_forced_nack_drop: assert property (@(posedge pclk) disable iff (!presetn)
      ce && slave_rx.valid && force_nack |=> slave_nack && slave_abort && !rx_push)
      else $error("forced nack did not drop the byte");

   a_normal_ack_push: assert property (@(posedge pclk) disable iff (!presetn)
      ce && slave_rx.valid && !force_nack |=> rx_push == !slave_nack && rx_push == $past(slave_rx.normal_ack))
      else $error("normal acknowledge not followed");

   a_abort_clear: assert property (@(posedge pclk) disable iff (!presetn)
      ce && rd_done && paddr == `ANK_OFF_CLR_ABORT && !(|abort_set)
      |=> (abort_src & $past(prdata[3:0])) == 4'h0)
      else $error("abort flags not cleared by clear read");

   a_abort_stop: assert property (@(posedge pclk) disable iff (!presetn)
      ce && |abort_set |=> master_stop_req && tx_abort ##1 (!ce || !tx_abort))
      else $error("abort did not end the transfer for one cycle");

   c_short_abort: cover property (@(posedge pclk) disable iff (!presetn)
      ce && abort_set.short_addr_not_acked);
   c_long2_abort: cover property (@(posedge pclk) disable iff (!presetn)
      ce && abort_set.long_addr_byte2_not_acked);
   c_forced_nack: cover property (@(posedge pclk) disable iff (!presetn)
      ce && slave_rx.valid && force_nack);
   c_irq_raise: cover property (@(posedge pclk) disable iff (!presetn)
      !irq ##1 irq);

endmodule
`default_nettype wire

// ### rtl/ank_defs.svh
// Register offsets, field positions and reset values of the abort and slave NACK block
`ifndef ANK_DEFS_SVH
`define ANK_DEFS_SVH

// ==========================================================
// Register offsets (byte addresses, paddr[11:0])
`define ANK_OFF_INTR_STAT  12'h02c
`define ANK_OFF_INTR_MASK  12'h030
`define ANK_OFF_CLR_ABORT  12'h054
`define ANK_OFF_ENABLE     12'h06c
`define ANK_OFF_STATUS     12'h070
`define ANK_OFF_ABORT_SRC  12'h080
`define ANK_OFF_NACK_CTRL  12'h084

// ==========================================================
// Field positions
`define ANK_BIT_ENABLE     0
`define ANK_BIT_SLV_ACT    6
`define ANK_INT_TX_ABORT   0
`define ANK_INT_SLV_NACK   1

// ==========================================================
// Reset values
`define ANK_RST_NACK       1'h0
`define ANK_RST_ENABLE     1'h0
`define ANK_RST_MASK       2'h3

// ==========================================================
// Serial framing
`define ANK_ACK_SLOT       4'h8
`define ANK_DIR_SLOT       4'h7

`endif

// ### rtl/ank_pkg.sv
// Types shared by the abort and slave NACK block
package ank_pkg;

   // Acknowledge-failure abort flags, bit 3 down to bit 0
   typedef struct packed {
      logic data_not_acked;
      logic long_addr_byte2_not_acked;
      logic long_addr_byte1_not_acked;
      logic short_addr_not_acked;
   } ank_abort_t;

   // One received data byte offered by the slave receiver
   typedef struct packed {
      logic       valid;
      logic       normal_ack;
      logic [7:0] data;
   } ank_slv_rx_t;

   // Phase of the transfer on the serial bus
   typedef enum logic [3:0] {
      PH_IDLE  = 4'b0001,
      PH_ADDR1 = 4'b0010,
      PH_ADDR2 = 4'b0100,
      PH_DATA  = 4'b1000
   } ank_phase_t;

endpackage

// ### test/ank_bus_model.sv
// Remote serial bus parties: drives the block's clock and data pins
`timescale 1ns/1ps
`default_nettype none

module ank_bus_model (
   output logic scl, // Serial clock seen by the block
   output logic sda  // Serial data seen by the block, pulled up
);
   localparam int HALF = 32;

   // Idle bus: both lines released to the pull-up, clock stands still
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end

   // ==========================================================
   // Framing
   task automatic start();
      sda = 1'b0;
      #(HALF);
      scl = 1'b0;
      #(HALF / 2);
   endtask

   task automatic bit_out(input logic b);
      sda = b;
      #(HALF / 2);
      scl = 1'b1;
      #(HALF);
      scl = 1'b0;
      #(HALF / 2);
   endtask

   // Eight bits msb first, then the acknowledge slot (1 = released, no ack)
   task automatic send(input logic [7:0] b, input logic nack);
      for (int i = 7; i >= 0; i--) begin
         bit_out(b[i]);
      end
      bit_out(nack);
   endtask

   task automatic stop();
      sda = 1'b0;
      #(HALF / 2);
      scl = 1'b1;
      #(HALF / 2);
      sda = 1'b1;
      #(HALF);
   endtask
endmodule

`default_nettype wire

// ### test/ank_abort_nack_tb_top.sv
// Self-checking bench for the abort flags and forced slave data NACK
`timescale 1ns/1ps
`default_nettype none
`include "ank_defs.svh"

module ank_abort_nack_tb_top;
   logic                 pclk, presetn, psel, penable, pwrite, scl_in, sda_in, ce;
   logic [11:0]          paddr;
   logic [31:0]          pwdata, prdata, rd;
   logic                 pready, pslverr, er, master_mode, addr_10bit, slave_activity;
   ank_pkg::ank_slv_rx_t slave_rx;
   logic                 rx_push, slave_nack, slave_abort, master_stop_req, tx_abort, controller_en, irq;
   logic [7:0]           rx_push_data;
   int                   fails, compares, n_abort;

   ank_abort_nack i_ank_abort_nack (.pclk(pclk), .presetn(presetn), .ce(ce), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .scl_in(scl_in), .sda_in(sda_in), .master_mode(master_mode), .addr_10bit(addr_10bit),
      .slave_activity(slave_activity), .slave_rx(slave_rx), .rx_push(rx_push), .rx_push_data(rx_push_data),
      .slave_nack(slave_nack), .slave_abort(slave_abort), .master_stop_req(master_stop_req),
      .tx_abort(tx_abort), .controller_en(controller_en), .irq(irq));
   ank_bus_model i_ank_bus_model (.scl(scl_in), .sda(sda_in));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   // Abort pulses seen with the stop request beside them
   always @(negedge pclk) begin
      if (tx_abort === 1'b1 && master_stop_req === 1'b1) n_abort++;
   end

   // ==========================================================
   // Checking and closing
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // Expected {push, nack, abort} for one received slave byte
   function automatic logic [2:0] rx_exp(input logic force_nack, input logic ok);
      return force_nack ? 3'b011 : {ok, ~ok, 1'b0};
   endfunction

   // ==========================================================
   // APB master
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      // Ready looked at mid-cycle, so the ending edge still sees the request
      @(negedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(negedge pclk);
         n++;
      end
      if (n >= 20) chk(32'h0000_0000, 32'h0000_0001);
      @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   // One slave data byte, outputs looked at in the cycle after it is taken
   task automatic srx(input logic force_nack);
      logic [7:0] d;
      logic       ok;
      d = 8'($urandom);
      ok = 1'($urandom);
      slave_rx <= {1'b1, ok, d};
      @(posedge pclk);
      slave_rx <= {2'b00, d};
      @(negedge pclk);
      chk({29'h0, rx_push, slave_nack, slave_abort}, {29'h0, rx_exp(force_nack, ok)});
      chk({24'h0, rx_push_data}, {24'h0, d});
      @(posedge pclk);
   endtask

   // One master transfer with a missing acknowledge after okb acked bytes
   task automatic run_case(input logic ten, input int okb, input logic [3:0] exp, input logic mm, input logic ei);
      logic [7:0] b;
      int         a0;
      a0 = n_abort;
      master_mode <= mm;
      addr_10bit <= ten;
      @(posedge pclk);
      i_ank_bus_model.start();
      for (int i = 0; i <= okb; i++) begin
         b = 8'($urandom);
         if (i == 0) b = ten ? {5'h1e, b[2:1], 1'b0} : {b[7:1], 1'b0};
         i_ank_bus_model.send(b, i == okb);
      end
      i_ank_bus_model.stop();
      repeat (8) @(posedge pclk);
      chk(32'(n_abort - a0), {31'h0, exp != 4'h0});
      chk({31'h0, irq}, {31'h0, ei});
      apb(1'b0, `ANK_OFF_ABORT_SRC, 32'h0);
      chk(rd, {28'h0, exp});
      apb(1'b0, `ANK_OFF_INTR_STAT, 32'h0);
      chk(rd, {31'h0, exp != 4'h0});
      apb(1'b0, `ANK_OFF_CLR_ABORT, 32'h0);
      chk(rd, {28'h0, exp});
      apb(1'b0, `ANK_OFF_ABORT_SRC, 32'h0);
      chk(rd, 32'h0);
   endtask

   // ==========================================================
   // Main sequence
   localparam logic [6:0] C_TEN = 7'b0011100, C_MM = 7'b1011111, C_IRQ = 7'b0011111;
   localparam int         C_OK [7] = '{0, 1, 0, 1, 2, 0, 0};
   localparam logic [3:0] C_EXP [7] = '{4'h1, 4'h8, 4'h2, 4'h4, 4'h8, 4'h0, 4'h1};

   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
      master_mode = 1'b0; addr_10bit = 1'b0; slave_activity = 1'b0; slave_rx = '0;
      ce = 1'b1;
      n_abort = 0;
      fails = 0;
      compares = 0;
      void'($urandom(11960));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `ANK_OFF_NACK_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, `ANK_OFF_INTR_MASK, 32'h0);
      chk(rd, 32'h3);
      apb(1'b0, 12'h004, 32'h0);
      chk({31'h0, er}, 32'h1);
      apb(1'b1, `ANK_OFF_ENABLE, 32'h1);
      chk({31'h0, controller_en}, 32'h1);
      apb(1'b1, `ANK_OFF_NACK_CTRL, 32'h1);
      apb(1'b0, `ANK_OFF_NACK_CTRL, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, `ANK_OFF_ENABLE, 32'h0);
      slave_activity <= 1'b1;
      apb(1'b0, `ANK_OFF_STATUS, 32'h0);
      chk(rd, 32'h40);
      apb(1'b1, `ANK_OFF_NACK_CTRL, 32'h1);
      apb(1'b0, `ANK_OFF_NACK_CTRL, 32'h0);
      chk(rd, 32'h0);
      slave_activity <= 1'b0;
      apb(1'b0, `ANK_OFF_STATUS, 32'h0);
      chk(rd, 32'h0);
      apb(1'b1, `ANK_OFF_NACK_CTRL, 32'h1);
      apb(1'b0, `ANK_OFF_NACK_CTRL, 32'h0);
      chk(rd, 32'h1);
      repeat (6) srx(1'b1);
      apb(1'b0, `ANK_OFF_INTR_STAT, 32'h0);
      chk(rd, 32'h2);
      apb(1'b1, `ANK_OFF_NACK_CTRL, 32'h0);
      repeat (8) srx(1'b0);
      // A byte offered while the clock enable is low is not seen
      ce <= 1'b0;
      slave_rx <= {1'b1, 1'b1, 8'h5a};
      @(posedge pclk);
      ce <= 1'b1;
      slave_rx <= '0;
      @(negedge pclk);
      chk({31'h0, rx_push}, 32'h0);
      @(posedge pclk);
      apb(1'b1, `ANK_OFF_ENABLE, 32'h1);
      for (int i = 0; i < 7; i++) begin
         if (i == 6) apb(1'b1, `ANK_OFF_INTR_MASK, 32'h0);
         run_case(C_TEN[i], C_OK[i], C_EXP[i], C_MM[i], C_IRQ[i]);
      end
      report_and_stop();
   end

   // Watchdog: the whole run needs well under this span
   initial begin
      #200000;
      fails++;
      report_and_stop();
   end
endmodule

`default_nettype wire
